// ### shared/sssa_defs.svh
`ifndef SSSA_DEFS_SVH
`define SSSA_DEFS_SVH
`define SSSA_W              16
`define SSSA_CLK_HZ         10000000
`define SSSA_TICK_US        1000
`define SSSA_TICK_CYC       ((`SSSA_CLK_HZ / 1000000) * `SSSA_TICK_US)
`define SSSA_MA_LOW_UA      3000
`define SSSA_MA_HIGH_UA     21000
`define SSSA_DB_PCT         10
`define SSSA_DB_FULL        16'h00FF
`define SSSA_RATE_RST       16'h0010
`define SSSA_DB_RST         16'h0010
`define SSSA_NPARAM         4
`endif

// ### shared/sssa_pkg.sv
package sssa_pkg;
  typedef enum logic [2:0] {
    SSSA_TGT_NONE = 3'b001,
    SSSA_TGT_RATE = 3'b010,
    SSSA_TGT_DB   = 3'b100
  } sssa_tgt_e;
  typedef struct packed {
    logic dynamics_view_key;
    logic step;
    logic rate_sel;
    logic db_sel;
    logic adj_up;
    logic adj_dn;
    logic yes;
    logic no;
    logic clear;
  } sssa_keys_s;
  typedef struct packed {
    logic [15:0] min_ref;
    logic [15:0] max_ctl;
    logic [15:0] remote_rate;
    logic [15:0] fast_rate;
    logic [15:0] cas_ref;
    logic [15:0] cas_range;
    logic [15:0] spd_range;
    logic        brk_shutdown_cfg;
    logic        brk_alarm_cfg;
  } sssa_cfg_s;
endpackage

// ### src/sssa_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "sssa_defs.svh"
module sssa_tick #(
  parameter int CYC = `SSSA_TICK_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick
);
  logic [31:0] cnt_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 32'h0;
      tick  <= 1'b0;
    end else begin
      tick  <= (cnt_q == 32'(CYC - 1));
      cnt_q <= (cnt_q == 32'(CYC - 1)) ? 32'h0 : cnt_q + 32'h1;
    end
  end
endmodule
`default_nettype wire

// ### src/sssa_arbiter.sv
// Summary of operation
// - Emergency shutdown or low select first, equal rank
// - Fixed speed source priority order
// - Fixed valve ramp command priority
// - Dynamics key shows controlling parameter; step advances
// - Deadband key, or rate key off the remote page, sets target, enables adjust
// - Step key disables adjust, clears target
// - Flag parameter controlling actuator
// - Both enabled: neither controls, sticky alarm
// - Secondary moves clamped min to max
// - Input out of range holds setpoint, alarm
// - Breakers must be closed to enable
// - Breaker open response is configurable
// - Yes key or contact enables remote
// - Unmatched remote ramps until within deadband
// - Lower any time, raise only speed-controlling
// - No key or contact disables remote
// - Cascade removes error outside deadband
// - Cascade rate proportional, limited to fast
// - Remote moves at single fixed rate
// - Full deadband is ten percent range
// - Secondary dynamics: keys target rate/deadband
`timescale 1ns/1ps
`default_nettype none
`include "sssa_defs.svh"
module sssa_arbiter #(
  parameter int W      = `SSSA_W,
  parameter int TICK_N = `SSSA_TICK_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire sssa_pkg::sssa_keys_s keys,
  input  wire sssa_pkg::sssa_cfg_s  cfg,
  input  wire logic                remote_view_key,
  input  wire logic                cas_view_key,
  input  wire logic                rmt_contact,
  input  wire logic                cas_contact,
  input  wire logic                gen_brk_closed,
  input  wire logic                tie_brk_closed,
  input  wire logic [W-1:0]        rmt_ma_ua,
  input  wire logic [W-1:0]        cas_ma_ua,
  input  wire logic [W-1:0]        rmt_req_spd,
  input  wire logic [W-1:0]        cas_input,
  input  wire logic [W-1:0]        actual_spd,
  input  wire logic                speed_in_ctl,
  input  wire logic                esd,
  input  wire logic                lss_active,
  input  wire logic                brk_reset_req,
  input  wire logic [W-1:0]        brk_reset_spd,
  input  wire logic                clamp_req,
  input  wire logic [W-1:0]        clamp_spd,
  input  wire logic                crit_req,
  input  wire logic [W-1:0]        crit_spd,
  input  wire logic                rl_req,
  input  wire logic [W-1:0]        rl_spd,
  input  wire logic                idle_req,
  input  wire logic [W-1:0]        idle_spd,
  input  wire logic [4:0]          vr_req,
  input  wire logic [1:0]          ctl_param,
  output logic [W-1:0]             speed_ref_q,
  output logic                     shutdown_q,
  output logic                     alarm_q,
  output logic                     both_enabled_indication_alarm_q,
  output logic                     rmt_enabled_indication_q,
  output logic                     cas_enabled_indication_q,
  output logic [1:0]               shown_param_q,
  output logic                     ctl_flag_q,
  output logic [2:0]               adj_target_q,
  output logic                     adjust_updown_keys_q,
  output logic [W-1:0]             cas_rate_q,
  output logic [W-1:0]             rmt_deadband_width_q,
  output logic [W-1:0]             cas_deadband_width_q,
  output logic [2:0]               spd_src_q,
  output logic [4:0]               vr_grant_q
);
  localparam logic [1:0] P_RMT = 2'h2;
  localparam logic [1:0] P_CAS = 2'h3;

  // Contacts, breakers and analogue values come from outside: two stages
  localparam int NS = 9;
  logic [NS-1:0] s1_q, s2_q;
  logic [W-1:0]  rma1_q, rma2_q, cma1_q, cma2_q;
  always_ff @(posedge clk) begin
    s1_q   <= {rmt_contact, cas_contact, gen_brk_closed, tie_brk_closed,
               speed_in_ctl, esd, lss_active, brk_reset_req, clamp_req};
    s2_q   <= s1_q;
    rma1_q <= rmt_ma_ua;
    rma2_q <= rma1_q;
    cma1_q <= cas_ma_ua;
    cma2_q <= cma1_q;
  end
  wire rmt_ct = s2_q[8];
  wire cas_ct = s2_q[7];
  wire brk_ok = s2_q[6] & s2_q[5];
  wire spd_ctl = s2_q[4];
  wire esd_s  = s2_q[3];
  wire lss_s  = s2_q[2];
  wire brr_s  = s2_q[1];
  wire clp_s  = s2_q[0];

  logic rct_q, cct_q;
  wire tick;
  sssa_tick #(.CYC(TICK_N)) u_tick (.clk(clk), .rst_n(rst_n), .tick(tick));

  // Enable requests
  wire rmt_on_req  = (keys.yes & remote_view_key) | (rmt_ct & ~rct_q);
  wire rmt_off_req = (keys.no & remote_view_key) | (~rmt_ct & rct_q);
  wire cas_on_req  = (keys.yes & cas_view_key) | (cas_ct & ~cct_q);
  wire cas_off_req = (keys.no & cas_view_key) | (~cas_ct & cct_q);
  // Opening a breaker drops both enables on the spot
  wire rmt_en_d = brk_ok & ~rmt_off_req & (rmt_enabled_indication_q | rmt_on_req);
  wire cas_en_d = brk_ok & ~cas_off_req & (cas_enabled_indication_q | cas_on_req);
  wire both_en  = rmt_enabled_indication_q & cas_enabled_indication_q;

  // Signal range checks
  wire rmt_bad = (rma2_q < W'(`SSSA_MA_LOW_UA)) | (rma2_q > W'(`SSSA_MA_HIGH_UA));
  wire cas_bad = (cma2_q < W'(`SSSA_MA_LOW_UA)) | (cma2_q > W'(`SSSA_MA_HIGH_UA));
  wire sig_alarm = (rmt_bad & rmt_enabled_indication_q) | (cas_bad & cas_enabled_indication_q);
  wire rmt_go = rmt_enabled_indication_q & ~both_en & ~rmt_bad & brk_ok;
  wire cas_go = cas_enabled_indication_q & ~both_en & ~cas_bad & brk_ok;

  // Deadband scaled: width setting/full * 10% of range
  wire [31:0] rmt_db = (32'(cfg.spd_range) * `SSSA_DB_PCT * 32'(rmt_deadband_width_q))
                       / (100 * `SSSA_DB_FULL);
  wire [31:0] cas_db = (32'(cfg.cas_range) * `SSSA_DB_PCT * 32'(cas_deadband_width_q))
                       / (100 * `SSSA_DB_FULL);

  // Remote: fixed rate toward request while outside deadband
  wire        r_up   = rmt_req_spd > speed_ref_q;
  wire [W-1:0] r_err = (rmt_req_spd > actual_spd) ? rmt_req_spd - actual_spd
                       : actual_spd - rmt_req_spd;
  wire        r_out  = r_err > W'(rmt_db);
  wire [W-1:0] r_step = cfg.remote_rate;

  // Cascade: rate proportional to excess error, capped at fast rate
  wire        c_up   = cas_input < cfg.cas_ref;
  wire [W-1:0] c_err = c_up ? cfg.cas_ref - cas_input : cas_input - cfg.cas_ref;
  wire        c_out  = 32'(c_err) > cas_db;
  wire [31:0] c_prod = ((32'(c_err) - cas_db) * 32'(cas_rate_q)) >> 8;
  wire [W-1:0] c_step = (c_prod > 32'(cfg.fast_rate)) ? cfg.fast_rate : W'(c_prod);

  // Secondary candidate; raise only when speed loop holds actuator
  wire          sec_up   = rmt_go ? r_up : c_up;
  wire [W-1:0]  sec_step = rmt_go ? r_step : c_step;
  wire [W:0]    sec_hi   = {1'b0, speed_ref_q} + {1'b0, sec_step};
  // Lowering saturates at zero instead of wrapping to the top
  wire [W-1:0]  sec_lo   = (sec_step > speed_ref_q) ? '0 : speed_ref_q - sec_step;
  logic         sec_act;
  logic [W-1:0] sec_tgt;
  always_comb begin
    sec_act = (rmt_go && r_out && (!r_up || spd_ctl))
              || (cas_go && c_out && (!c_up || spd_ctl));
    sec_tgt = speed_ref_q;
    if (sec_act) begin
      sec_tgt = sec_up ? sec_hi[W-1:0] : sec_lo;
    end
    if (sec_tgt > cfg.max_ctl || (sec_act && sec_up && sec_hi[W])) begin
      sec_tgt = cfg.max_ctl;
    end
    if (sec_tgt < cfg.min_ref) begin
      sec_tgt = cfg.min_ref;
    end
  end

  // Speed source priority, highest first
  logic [2:0]   src_d;
  logic [W-1:0] ref_d;
  always_comb begin
    src_d = 3'h7;
    ref_d = speed_ref_q;
    if (esd_s || lss_s) begin
      src_d = 3'h0;
    end else if (brr_s) begin
      src_d = 3'h1;
      ref_d = brk_reset_spd;
    end else if (alarm_q) begin
      src_d = 3'h2;
    end else if (clp_s) begin
      src_d = 3'h3;
      ref_d = clamp_spd;
    end else if (crit_req) begin
      src_d = 3'h4;
      ref_d = crit_spd;
    end else if (sec_act) begin
      src_d = 3'h5;
      ref_d = sec_tgt;
    end else if (rl_req) begin
      src_d = 3'h6;
      ref_d = rl_spd;
    end else if (idle_req) begin
      src_d = 3'h7;
      ref_d = idle_spd;
    end
  end

  // Valve ramp: lowest index wins
  wire [4:0] vr_gnt = vr_req & (~vr_req + 5'h1);

  // Breaker open response
  wire brk_evt = ~brk_ok & (rmt_enabled_indication_q | cas_enabled_indication_q);
  wire brk_shd = brk_evt & cfg.brk_shutdown_cfg;
  wire brk_alm = ~brk_ok & cfg.brk_alarm_cfg & ~brk_shd;
  wire new_alm = sig_alarm | both_en | brk_alm;

  // Adjustment target handling
  wire is_sec = (shown_param_q == P_RMT) | (shown_param_q == P_CAS);
  logic [2:0] tgt_d;
  always_comb begin
    tgt_d = adj_target_q;
    case (adj_target_q)
      sssa_pkg::SSSA_TGT_NONE,
      sssa_pkg::SSSA_TGT_RATE,
      sssa_pkg::SSSA_TGT_DB: begin
        if (keys.step || keys.dynamics_view_key) begin
          tgt_d = sssa_pkg::SSSA_TGT_NONE;
        end else if (keys.rate_sel && shown_param_q != P_RMT) begin
          tgt_d = sssa_pkg::SSSA_TGT_RATE;
        end else if (keys.db_sel) begin
          tgt_d = sssa_pkg::SSSA_TGT_DB;
        end
      end
      default: tgt_d = sssa_pkg::SSSA_TGT_NONE;
    endcase
  end
  wire adj_on = adj_target_q != sssa_pkg::SSSA_TGT_NONE;
  wire adj_rate = adj_on & is_sec & (adj_target_q == sssa_pkg::SSSA_TGT_RATE);
  wire adj_db   = adj_on & is_sec & (adj_target_q == sssa_pkg::SSSA_TGT_DB);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rct_q <= 1'b0;
      cct_q <= 1'b0;
      rmt_enabled_indication_q <= 1'b0;
      cas_enabled_indication_q <= 1'b0;
      both_enabled_indication_alarm_q <= 1'b0;
      alarm_q <= 1'b0;
      shutdown_q <= 1'b0;
    end else begin
      rct_q <= rmt_ct;
      cct_q <= cas_ct;
      rmt_enabled_indication_q <= rmt_en_d;
      cas_enabled_indication_q <= cas_en_d;
      // Clear blocked while both remain enabled; set beats clear
      both_enabled_indication_alarm_q <= both_en | (both_enabled_indication_alarm_q & ~keys.clear);
      alarm_q <= new_alm | (alarm_q & ~(keys.clear & ~both_en));
      shutdown_q <= shutdown_q | esd_s | brk_shd;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      speed_ref_q <= '0;
      spd_src_q   <= 3'h7;
      vr_grant_q  <= 5'h0;
    end else if (tick) begin
      speed_ref_q <= ref_d;
      spd_src_q   <= src_d;
      vr_grant_q  <= vr_gnt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shown_param_q        <= 2'h0;
      ctl_flag_q           <= 1'b0;
      adj_target_q         <= sssa_pkg::SSSA_TGT_NONE;
      adjust_updown_keys_q <= 1'b0;
      cas_rate_q           <= `SSSA_RATE_RST;
      rmt_deadband_width_q <= `SSSA_DB_RST;
      cas_deadband_width_q <= `SSSA_DB_RST;
    end else begin
      if (keys.dynamics_view_key) begin
        shown_param_q <= ctl_param;
      end else if (keys.step) begin
        shown_param_q <= shown_param_q + 2'h1;
      end
      ctl_flag_q <= (keys.dynamics_view_key ? ctl_param : shown_param_q) == ctl_param;
      adj_target_q <= tgt_d;
      adjust_updown_keys_q <= tgt_d != sssa_pkg::SSSA_TGT_NONE;
      if (adj_rate && shown_param_q == P_CAS && keys.adj_up && cas_rate_q != '1) begin
        cas_rate_q <= cas_rate_q + W'(1);
      end else if (adj_rate && shown_param_q == P_CAS && keys.adj_dn && cas_rate_q != '0) begin
        cas_rate_q <= cas_rate_q - W'(1);
      end
      if (adj_db && shown_param_q == P_RMT) begin
        if (keys.adj_up && rmt_deadband_width_q < `SSSA_DB_FULL) begin
          rmt_deadband_width_q <= rmt_deadband_width_q + W'(1);
        end else if (keys.adj_dn && rmt_deadband_width_q != '0) begin
          rmt_deadband_width_q <= rmt_deadband_width_q - W'(1);
        end
      end
      if (adj_db && shown_param_q == P_CAS) begin
        if (keys.adj_up && cas_deadband_width_q < `SSSA_DB_FULL) begin
          cas_deadband_width_q <= cas_deadband_width_q + W'(1);
        end else if (keys.adj_dn && cas_deadband_width_q != '0) begin
          cas_deadband_width_q <= cas_deadband_width_q - W'(1);
        end
      end
    end
  end

  both_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    both_en |=> both_enabled_indication_alarm_q)
    else $error("both-enabled alarm not raised");
  brk_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
    !brk_ok |=> !rmt_enabled_indication_q && !cas_enabled_indication_q)
    else $error("enable held with breaker open");
  ref_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick && src_d == 3'h5 |=> speed_ref_q >= cfg.min_ref && speed_ref_q <= cfg.max_ctl)
    else $error("secondary moved reference out of span");
  step_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    keys.step |=> !adjust_updown_keys_q && adj_target_q == sssa_pkg::SSSA_TGT_NONE)
    else $error("step left adjust active");
  tick_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    !tick |=> $stable(speed_ref_q))
    else $error("reference moved off tick");
  esd_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick && esd_s |=> spd_src_q == 3'h0 && shutdown_q)
    else $error("shutdown not top priority");
  raise_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick && src_d == 3'h5 && !spd_ctl |=> speed_ref_q <= $past(speed_ref_q))
    else $error("secondary raised without speed control");
  vr_onehot_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick && vr_req[0] |=> vr_grant_q == 5'h01)
    else $error("clamp not top valve priority");
  dyn_view_a: assert property (@(posedge clk) disable iff (!rst_n)
    keys.dynamics_view_key |=> shown_param_q == $past(ctl_param) && ctl_flag_q)
    else $error("dynamics view not controlling parameter");
  sig_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    rmt_bad && rmt_enabled_indication_q |=> alarm_q)
    else $error("bad input without alarm");

  rmt_enable_c: cover property (@(posedge clk) disable iff (!rst_n)
    !rmt_enabled_indication_q ##1 rmt_enabled_indication_q);
  cas_move_c: cover property (@(posedge clk) disable iff (!rst_n)
    tick && cas_go && sec_act);
  both_en_c: cover property (@(posedge clk) disable iff (!rst_n) both_enabled_indication_alarm_q);
  db_adj_c: cover property (@(posedge clk) disable iff (!rst_n)
    adj_db && keys.adj_up);
endmodule
`default_nettype wire

// ### verif/sssa_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module sssa_far_side (
  input  wire logic            clk,
  output sssa_pkg::sssa_keys_s keys,
  output logic                 remote_view_key,
  output logic                 cas_view_key,
  output logic                 rmt_contact,
  output logic                 cas_contact,
  output logic                 gen_brk_closed,
  output logic                 tie_brk_closed,
  output logic [15:0]          rmt_ma_ua,
  output logic [15:0]          cas_ma_ua,
  output logic [15:0]          rmt_req_spd,
  output logic [15:0]          cas_input
);
  initial begin
    keys = '0;
    {remote_view_key, cas_view_key, rmt_contact, cas_contact} = 4'h0;
    {gen_brk_closed, tie_brk_closed} = 2'h3;
    rmt_ma_ua = 16'h2EE0;
    cas_ma_ua = 16'h2EE0;
    rmt_req_spd = 16'h1000;
    cas_input = 16'h1000;
  end
  // Keypad gives one-cycle pulses; yes/no act on the page in view
  task automatic press(input sssa_pkg::sssa_keys_s k);
    @(negedge clk);
    keys = k;
    @(negedge clk);
    keys = '0;
  endtask
  task automatic view(input logic r, input logic c);
    @(negedge clk);
    remote_view_key = r;
    cas_view_key = c;
  endtask
  // Contacts are levels; the arbiter acts on their edges
  task automatic contacts(input logic r, input logic c);
    @(negedge clk);
    rmt_contact = r;
    cas_contact = c;
  endtask
  task automatic breakers(input logic g, input logic t);
    @(negedge clk);
    gen_brk_closed = g;
    tie_brk_closed = t;
  endtask
  // Both loops move together; only an enabled function may alarm
  task automatic loop_ma(input logic [15:0] ma);
    @(negedge clk);
    rmt_ma_ua = ma;
    cas_ma_ua = ma;
  endtask
  task automatic demand(input logic [15:0] r, input logic [15:0] c);
    @(negedge clk);
    rmt_req_spd = r;
    cas_input = c;
  endtask
endmodule
`default_nettype wire

// ### verif/secondary_speed_setpoint_arbiter_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module secondary_speed_setpoint_arbiter_test;
  localparam int TN = 10;
  localparam int KCLR = 0, KNO = 1, KYES = 2, KDN = 3, KUP = 4, KDB = 5, KRATE = 6;
  localparam int KSTEP = 7, KDYN = 8;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  int                   errors = 0;
  int                   checks = 0;
  sssa_pkg::sssa_keys_s keys;
  sssa_pkg::sssa_cfg_s  cfg;
  logic                 remote_view_key, cas_view_key, rmt_contact, cas_contact;
  logic                 gen_brk_closed, tie_brk_closed;
  logic [15:0]          rmt_ma_ua, cas_ma_ua, rmt_req_spd, cas_input, actual_spd;
  logic                 speed_in_ctl, esd, lss_active, brk_reset_req, clamp_req;
  logic                 crit_req, rl_req, idle_req;
  logic [4:0]           vr_req, vr_grant_q;
  logic [1:0]           ctl_param, shown_param_q;
  logic [15:0]          speed_ref_q, cas_rate_q, rmt_deadband_width_q, cas_deadband_width_q;
  logic                 shutdown_q, alarm_q, both_enabled_indication_alarm_q, ctl_flag_q;
  logic                 rmt_enabled_indication_q, cas_enabled_indication_q;
  logic                 adjust_updown_keys_q;
  logic [2:0]           adj_target_q, spd_src_q;

  always #50 clk = ~clk;

  sssa_far_side far (.clk(clk), .keys(keys), .remote_view_key(remote_view_key),
    .cas_view_key(cas_view_key), .rmt_contact(rmt_contact), .cas_contact(cas_contact),
    .gen_brk_closed(gen_brk_closed), .tie_brk_closed(tie_brk_closed),
    .rmt_ma_ua(rmt_ma_ua), .cas_ma_ua(cas_ma_ua), .rmt_req_spd(rmt_req_spd),
    .cas_input(cas_input));

  sssa_arbiter #(.W(16), .TICK_N(TN)) dut (.clk(clk), .rst_n(rst_n), .keys(keys),
    .cfg(cfg), .remote_view_key(remote_view_key), .cas_view_key(cas_view_key),
    .rmt_contact(rmt_contact), .cas_contact(cas_contact), .gen_brk_closed(gen_brk_closed),
    .tie_brk_closed(tie_brk_closed), .rmt_ma_ua(rmt_ma_ua), .cas_ma_ua(cas_ma_ua),
    .rmt_req_spd(rmt_req_spd), .cas_input(cas_input), .actual_spd(actual_spd),
    .speed_in_ctl(speed_in_ctl), .esd(esd), .lss_active(lss_active),
    .brk_reset_req(brk_reset_req), .brk_reset_spd(16'h0E00), .clamp_req(clamp_req),
    .clamp_spd(16'h0D00), .crit_req(crit_req), .crit_spd(16'h0C00), .rl_req(rl_req),
    .rl_spd(16'h0B00), .idle_req(idle_req), .idle_spd(16'h0A00), .vr_req(vr_req),
    .ctl_param(ctl_param), .speed_ref_q(speed_ref_q), .shutdown_q(shutdown_q),
    .alarm_q(alarm_q), .both_enabled_indication_alarm_q(both_enabled_indication_alarm_q),
    .rmt_enabled_indication_q(rmt_enabled_indication_q),
    .cas_enabled_indication_q(cas_enabled_indication_q), .shown_param_q(shown_param_q),
    .ctl_flag_q(ctl_flag_q), .adj_target_q(adj_target_q),
    .adjust_updown_keys_q(adjust_updown_keys_q), .cas_rate_q(cas_rate_q),
    .rmt_deadband_width_q(rmt_deadband_width_q),
    .cas_deadband_width_q(cas_deadband_width_q), .spd_src_q(spd_src_q),
    .vr_grant_q(vr_grant_q));

  task automatic hit(input int b);
    sssa_pkg::sssa_keys_s k;
    k = '0;
    k[b] = 1'b1;
    far.press(k);
    repeat (3) @(negedge clk);
  endtask
  // Synchronised pins need two flops plus one cycle to act
  task automatic settle();
    repeat (6) @(negedge clk);
  endtask

  task automatic t_keys();
    ctl_param = 2'h3;
    far.view(1'b0, 1'b1);
    hit(KDYN);
    `CHK("shown", 2'h3, shown_param_q)
    `CHK("flag", 1'b1, ctl_flag_q)
    hit(KDB);
    `CHK("target", 3'h4, adj_target_q)
    `CHK("adj_on", 1'b1, adjust_updown_keys_q)
    hit(KUP);
    `CHK("cas_db", 16'h0011, cas_deadband_width_q)
    hit(KSTEP);
    `CHK("target", 3'h1, adj_target_q)
    `CHK("adj_on", 1'b0, adjust_updown_keys_q)
    `CHK("flag", 1'b0, ctl_flag_q)
    hit(KUP);
    `CHK("cas_db", 16'h0011, cas_deadband_width_q)
    hit(KDYN);
    hit(KRATE);
    `CHK("target", 3'h2, adj_target_q)
    hit(KDN);
    `CHK("cas_rate", 16'h000F, cas_rate_q)
    ctl_param = 2'h2;
    far.view(1'b1, 1'b0);
    hit(KDYN);
    `CHK("shown", 2'h2, shown_param_q)
    `CHK("target", 3'h1, adj_target_q)
    hit(KRATE);
    `CHK("target", 3'h1, adj_target_q)
    hit(KDB);
    hit(KDN);
    `CHK("rmt_db", 16'h000F, rmt_deadband_width_q)
    hit(KSTEP);
    `CHK("shown", 2'h3, shown_param_q)
  endtask

  task automatic t_enable();
    hit(KYES);
    `CHK("rmt_en", 1'b1, rmt_enabled_indication_q)
    hit(KNO);
    `CHK("rmt_en", 1'b0, rmt_enabled_indication_q)
    far.contacts(1'b1, 1'b0);
    settle();
    `CHK("rmt_en", 1'b1, rmt_enabled_indication_q)
    far.contacts(1'b0, 1'b0);
    settle();
    `CHK("rmt_en", 1'b0, rmt_enabled_indication_q)
  endtask

  task automatic t_breaker();
    far.breakers(1'b0, 1'b1);
    settle();
    hit(KCLR);
    hit(KYES);
    `CHK("rmt_en", 1'b0, rmt_enabled_indication_q)
    far.breakers(1'b1, 1'b1);
    settle();
    hit(KYES);
    `CHK("rmt_en", 1'b1, rmt_enabled_indication_q)
    far.breakers(1'b1, 1'b0);
    settle();
    `CHK("rmt_en", 1'b0, rmt_enabled_indication_q)
    `CHK("alarm", 1'b1, alarm_q)
    `CHK("shutdown", 1'b0, shutdown_q)
    hit(KNO);
    far.breakers(1'b1, 1'b1);
    settle();
    hit(KCLR);
    `CHK("alarm", 1'b0, alarm_q)
    cfg.brk_alarm_cfg = 1'b0;
    far.breakers(1'b0, 1'b1);
    settle();
    `CHK("alarm", 1'b0, alarm_q)
    far.breakers(1'b1, 1'b1);
    settle();
    cfg.brk_alarm_cfg = 1'b1;
  endtask

  task automatic t_both();
    hit(KYES);
    far.view(1'b0, 1'b1);
    hit(KYES);
    `CHK("both", 1'b1, both_enabled_indication_alarm_q)
    hit(KCLR);
    `CHK("both", 1'b1, both_enabled_indication_alarm_q)
    hit(KNO);
    hit(KCLR);
    `CHK("both", 1'b0, both_enabled_indication_alarm_q)
    far.view(1'b1, 1'b0);
    hit(KNO);
  endtask

  task automatic t_range();
    hit(KYES);
    far.loop_ma(16'h07D0);
    settle();
    `CHK("alarm", 1'b1, alarm_q)
    hit(KNO);
    hit(KCLR);
    far.loop_ma(16'h55F0);
    settle();
    `CHK("alarm", 1'b0, alarm_q)
    far.loop_ma(16'h2EE0);
  endtask

  task automatic t_secondary();
    logic [15:0] r0;
    idle_req = 1'b1;
    repeat (2 * TN) @(negedge clk);
    `CHK("ref", 16'h0A00, speed_ref_q)
    idle_req = 1'b0;
    far.demand(16'h1400, 16'h1000);
    hit(KYES);
    r0 = speed_ref_q;
    repeat (TN) @(negedge clk);
    `CHK("rmt_up", r0 + 16'h0020, speed_ref_q)
    `CHK("src", 3'h5, spd_src_q)
    speed_in_ctl = 1'b0;
    repeat (3) @(negedge clk);
    r0 = speed_ref_q;
    repeat (TN) @(negedge clk);
    `CHK("no_raise", r0, speed_ref_q)
    far.demand(16'h0800, 16'h1000);
    r0 = speed_ref_q;
    repeat (TN) @(negedge clk);
    `CHK("rmt_dn", r0 - 16'h0020, speed_ref_q)
    actual_spd = 16'h0880;
    r0 = speed_ref_q;
    repeat (TN) @(negedge clk);
    `CHK("rmt_band", r0, speed_ref_q)
    hit(KNO);
    actual_spd = 16'h1000;
    r0 = speed_ref_q;
    repeat (TN) @(negedge clk);
    `CHK("rmt_off", r0, speed_ref_q)
    speed_in_ctl = 1'b1;
    far.view(1'b0, 1'b1);
    far.demand(16'h1000, 16'h0000);
    hit(KYES);
    r0 = speed_ref_q;
    repeat (TN) @(negedge clk);
    `CHK("cas_fast", r0 + 16'h0080, speed_ref_q)
    far.demand(16'h1000, 16'h0800);
    r0 = speed_ref_q;
    repeat (TN) @(negedge clk);
    `CHK("cas_slow", 1'b1, speed_ref_q > r0 && speed_ref_q < r0 + 16'h0080)
    far.demand(16'h1000, 16'h0FF0);
    r0 = speed_ref_q;
    repeat (TN) @(negedge clk);
    `CHK("cas_band", r0, speed_ref_q)
    hit(KNO);
    far.view(1'b1, 1'b0);
  endtask

  task automatic t_priority();
    logic [2:0] exp_src [5];
    exp_src = '{3'h1, 3'h3, 3'h4, 3'h6, 3'h7};
    vr_req = 5'h16;
    {brk_reset_req, clamp_req, crit_req, rl_req, idle_req} = 5'h1F;
    for (int i = 0; i < 5; i++) begin
      repeat (2 * TN + 6) @(negedge clk);
      `CHK("src", exp_src[i], spd_src_q)
      case (i)
        0: brk_reset_req = 1'b0;
        1: clamp_req = 1'b0;
        2: crit_req = 1'b0;
        3: rl_req = 1'b0;
        default: idle_req = 1'b0;
      endcase
    end
    `CHK("vr", 5'h02, vr_grant_q)
    vr_req = 5'h17;
    lss_active = 1'b1;
    repeat (2 * TN + 6) @(negedge clk);
    `CHK("src", 3'h0, spd_src_q)
    `CHK("vr", 5'h01, vr_grant_q)
    lss_active = 1'b0;
    repeat (2 * TN + 6) @(negedge clk);
    `CHK("src", 3'h7, spd_src_q)
    esd = 1'b1;
    repeat (2 * TN + 6) @(negedge clk);
    `CHK("src", 3'h0, spd_src_q)
    `CHK("shutdown", 1'b1, shutdown_q)
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (8000) @(posedge clk);
    errors++;
    wrap_up();
  end

  initial begin
    cfg = '{16'h0100, 16'hF000, 16'h0020, 16'h0080, 16'h1000, 16'h2000, 16'hFF00,
            1'b0, 1'b1};
    actual_spd = 16'h1000;
    {speed_in_ctl, esd, lss_active} = 3'h4;
    {brk_reset_req, clamp_req, crit_req, rl_req, idle_req} = 5'h00;
    vr_req = 5'h00;
    ctl_param = 2'h2;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    settle();
    `CHK("src_rst", 3'h7, spd_src_q)
    `CHK("tgt_rst", 3'h1, adj_target_q)
    `CHK("rate_rst", 16'h0010, cas_rate_q)
    `CHK("db_rst", 16'h0010, rmt_deadband_width_q)
    `CHK("db_rst", 16'h0010, cas_deadband_width_q)
    t_keys();
    t_enable();
    t_breaker();
    t_both();
    t_range();
    t_secondary();
    t_priority();
    wrap_up();
  end
endmodule
`default_nettype wire
